// ---- design/dfp_cfg.svh ----
// Offsets, field positions, reset values and timing figures of the fault protection block
`ifndef DFP_CFG_SVH
`define DFP_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DFP_IDX_GLOBAL_CONFIG_REG 6'h00
`define DFP_IDX_GLOBAL_STATUS_REG 6'h01
`define DFP_IDX_INPUT_STATUS_REG 6'h04
`define DFP_IDX_DRVCONF 6'h05
`define DFP_IDX_CHOP0 6'h10
`define DFP_IDX_CHOP1 6'h11
`define DFP_IDX_STAT0 6'h12
`define DFP_IDX_STAT1 6'h13
`define DFP_IDX_PWM0 6'h14
`define DFP_IDX_PWM1 6'h15

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DFP_GLOBAL_CONFIG_REG_DIAGNOSTIC_OUT_ZERO_ERR 3
`define DFP_GLOBAL_CONFIG_REG_DIAGNOSTIC_OUT_ZERO_UV 4
`define DFP_GLOBAL_CONFIG_REG_M0_DIS 14
`define DFP_GLOBAL_CONFIG_REG_M1_DIS 28
`define DFP_GLOBAL_STATUS_REG_UV 4
`define DFP_INPUT_STATUS_REG_TEMP_LSB 1
`define DFP_INPUT_STATUS_REG_TEMP_MSB 8
`define DFP_INPUT_STATUS_REG_ADC_EN 9
`define DFP_FSR0_LSB 0
`define DFP_FSR1_LSB 2
`define DFP_CHOPPER_OFF_TIME_MSB 3
`define DFP_ST_SHORT_GROUND_COIL_A_FLAG 0
`define DFP_ST_SHORT_GROUND_COIL_B_FLAG 1
`define DFP_ST_SHORT_SUPPLY_COIL_A_FLAG 2
`define DFP_ST_SHORT_SUPPLY_COIL_B_FLAG 3
`define DFP_ST_OLA 4
`define DFP_ST_OLB 5
`define DFP_ST_OT 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DFP_GLOBAL_CONFIG_REG_RST 32'h0000_0000
`define DFP_FSR_RST 2'h3
`define DFP_CHOPPER_OFF_TIME_RST 4'h3
`define DFP_ADC_EN_RST 1'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DFP_CLK_NS 20
`define DFP_BLANK_NS 500
`define DFP_RETRY_NS 2000
`define DFP_BLANK_CYC ((`DFP_BLANK_NS + `DFP_CLK_NS - 1) / `DFP_CLK_NS)
`define DFP_RETRY_CYC ((`DFP_RETRY_NS + `DFP_CLK_NS - 1) / `DFP_CLK_NS)
`define DFP_TRIES 3

`endif

// ---- design/dfp_pkg.sv ----
// Types shared by the fault protection block and its bench
`default_nettype none
package dfp_pkg;

  // Analog fault indications of one H-bridge
  typedef struct packed {
    logic overcurrent_protection;          // Output current above range threshold
    logic hs_gnd;       // High-side current says short to ground
    logic hs_sup;       // High-side current says short to supply
    logic open_load;    // Coil cannot reach commanded current
  } dfp_bridge_in_t;

  // Analog temperature and supply indications
  typedef struct packed {
    logic temp_hot;     // Die above shutdown level
    logic temp_cool;    // Die below release level
    logic vs_uvlo;      // Motor supply undervoltage
    logic vio_uvlo;     // I/O supply undervoltage
    logic adc_valid;    // Temperature code stable
  } dfp_analog_in_t;

  // Per-bridge protection state
  typedef enum logic [1:0] {
    DFP_ON = 2'b00,
    DFP_OFF = 2'b01,
    DFP_LATCHED = 2'b10
  } dfp_bstate_t;

endpackage
`default_nettype wire

// ---- design/dfp_top.sv ----
// Fault supervision and protection for four H-bridges with APB registers
`default_nettype none
`include "dfp_cfg.svh"

// Summary of operation
// R1 - Overcurrent counts only after staying above threshold beyond the blanking time.
// R2 - Each overcurrent event switches the affected bridge off at once.
// R3 - Third failed attempt latches bridge off and sets ground or supply short flag.
// R4 - Register writes and reads keep working while a bridge is latched off.
// R5 - Setting then clearing the motor disable bit re-enables a latched bridge.
// R6 - Zero off-time disables bridges; later nonzero value re-enables and clears latch.
// R7 - Overtemperature raises flag, tristates driver, restarts below release level.
// R8 - Averaged temperature code reads in input status bits eight down to one.
// R9 - Input status bit nine enables the temperature ADC; clearing stops measurement.
// R10 - Host converts temperature code to Celsius with slope and offset.
// R11 - Two-bit range per motor selects the overcurrent threshold.
// R12 - High-side current measurement catches shorts to ground and supply.
// R13 - Open-load flag sets when a coil cannot reach commanded current.
// R14 - Open-load flags never change driver operation.
// R15 - Host checks open-load only in fast decay after four full steps.
// R16 - Motor supply undervoltage sets a flag in global status.
// R17 - Undervoltage flag clears only by writing one to its bit.
// R18 - Undervoltage shows on active-low open-drain diagnostic pin when configured.
// R19 - During I/O supply undervoltage serial access is ignored.
// R20 - Readable per-motor scale registers report actual PWM duty sum.
// R21 - Retry counter returns to zero only when disable or zero off-time re-enables a bridge.
module dfp_top #(
  parameter int NUM_BRIDGES = 4,
  parameter int DUTY_W = 9
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog indications, asynchronous
  input wire dfp_pkg::dfp_bridge_in_t [NUM_BRIDGES-1:0] bridge_in,
  input wire dfp_pkg::dfp_analog_in_t analog_in,
  input wire logic [7:0] temp_adc_code,
  input wire logic [DUTY_W-1:0] motor0_pwm_duty,
  input wire logic [DUTY_W-1:0] motor1_pwm_duty,
  // Power stage control
  output logic [NUM_BRIDGES-1:0] bridge_enable,
  output logic driver_tristate,
  output logic [1:0] motor0_full_scale_range,
  output logic [1:0] motor1_full_scale_range,
  output logic temp_adc_enable,
  // Diagnostic pin, open drain
  output logic diagnostic_out_zero_o,
  output logic diagnostic_out_zero_oe
);
  import dfp_pkg::*;

  // Elaboration checks on parameters the logic cannot serve
  if (NUM_BRIDGES != 4) begin : g_nb_check
    $error("dfp_top serves exactly four bridges");
  end
  if (DUTY_W < 1 || DUTY_W > 32) begin : g_duty_check
    $error("dfp_top duty width out of range");
  end

  localparam int SYNC_W = 4 * NUM_BRIDGES + 5 + 8 + 2 * DUTY_W;
  localparam logic [7:0] BLANK_CYC = 8'(`DFP_BLANK_CYC);
  localparam logic [7:0] RETRY_CYC = 8'(`DFP_RETRY_CYC);
  localparam logic [1:0] TRIES = 2'(`DFP_TRIES);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Word index hit on the APB address
  function automatic logic idx_hit(input logic [31:0] addr, input logic [5:0] idx);
    idx_hit = (addr[7:2] == idx) && (addr[31:8] == 24'h00_0000) && (addr[1:0] == 2'h0);
  endfunction

  // Write-one-to-clear with set winning
  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    w1c = set | (cur & ~clr);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  wire logic [SYNC_W-1:0] async_in;
  assign async_in = {bridge_in, analog_in, temp_adc_code, motor0_pwm_duty, motor1_pwm_duty};

  // Two flops before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  dfp_bridge_in_t [NUM_BRIDGES-1:0] br_s;
  dfp_analog_in_t an_s;
  logic [7:0] adc_code_s;
  logic [DUTY_W-1:0] duty0_s;
  logic [DUTY_W-1:0] duty1_s;
  assign {br_s, an_s, adc_code_s, duty0_s, duty1_s} = sync2_r;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] global_config_reg_r;
  logic uv_flag_r;
  logic adc_en_r;
  logic [7:0] temp_r;
  logic [1:0] fsr0_r;
  logic [1:0] fsr1_r;
  logic [3:0] toff0_r;
  logic [3:0] toff1_r;
  logic ot_r;
  logic [31:0] prdata_r;

  // Access decode; I/O undervoltage blocks all access
  wire logic acc_ok = psel & ~an_s.vio_uvlo; // R19
  wire logic wr_en = acc_ok & penable & pwrite; // R4
  wire logic rd_setup = acc_ok & ~penable & ~pwrite;
  wire logic hit_global_config_reg = idx_hit(paddr, `DFP_IDX_GLOBAL_CONFIG_REG);
  wire logic hit_global_status_reg = idx_hit(paddr, `DFP_IDX_GLOBAL_STATUS_REG);
  wire logic hit_input_status_reg = idx_hit(paddr, `DFP_IDX_INPUT_STATUS_REG);
  wire logic hit_drv = idx_hit(paddr, `DFP_IDX_DRVCONF);
  wire logic hit_chop0 = idx_hit(paddr, `DFP_IDX_CHOP0);
  wire logic hit_chop1 = idx_hit(paddr, `DFP_IDX_CHOP1);
  wire logic hit_st0 = idx_hit(paddr, `DFP_IDX_STAT0);
  wire logic hit_st1 = idx_hit(paddr, `DFP_IDX_STAT1);
  wire logic hit_pwm0 = idx_hit(paddr, `DFP_IDX_PWM0);
  wire logic hit_pwm1 = idx_hit(paddr, `DFP_IDX_PWM1);
  wire logic mapped = hit_global_config_reg | hit_global_status_reg | hit_input_status_reg | hit_drv | hit_chop0 | hit_chop1 |
                      hit_st0 | hit_st1 | hit_pwm0 | hit_pwm1;

  // Zero-wait slave, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped & ~an_s.vio_uvlo;
  assign prdata = prdata_r;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_config_reg_r <= `DFP_GLOBAL_CONFIG_REG_RST;
      adc_en_r <= `DFP_ADC_EN_RST;
      fsr0_r <= `DFP_FSR_RST;
      fsr1_r <= `DFP_FSR_RST;
      toff0_r <= `DFP_CHOPPER_OFF_TIME_RST;
      toff1_r <= `DFP_CHOPPER_OFF_TIME_RST;
    end else begin
      if (wr_en && hit_global_config_reg) global_config_reg_r <= pwdata;
      if (wr_en && hit_input_status_reg) adc_en_r <= pwdata[`DFP_INPUT_STATUS_REG_ADC_EN]; // R9
      if (wr_en && hit_drv) begin
        fsr0_r <= pwdata[`DFP_FSR0_LSB +: 2]; // R11
        fsr1_r <= pwdata[`DFP_FSR1_LSB +: 2]; // R11
      end
      if (wr_en && hit_chop0) toff0_r <= pwdata[`DFP_CHOPPER_OFF_TIME_MSB:0];
      if (wr_en && hit_chop1) toff1_r <= pwdata[`DFP_CHOPPER_OFF_TIME_MSB:0];
    end
  end

  // Undervoltage flag, temperature capture, thermal state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_flag_r <= 1'b0;
      temp_r <= 8'h00;
      ot_r <= 1'b0;
    end else begin
      uv_flag_r <= w1c(uv_flag_r, an_s.vs_uvlo, wr_en & hit_global_status_reg & pwdata[`DFP_GLOBAL_STATUS_REG_UV]); // R16 R17
      if (adc_en_r && an_s.adc_valid) temp_r <= adc_code_s; // R8 R9
      if (an_s.temp_hot) ot_r <= 1'b1; // R7
      else if (an_s.temp_cool) ot_r <= 1'b0; // R7
    end
  end

  // ----------------------------------------------------------------
  // Short and overcurrent protection per bridge
  // ----------------------------------------------------------------
  dfp_bstate_t bstate_r [NUM_BRIDGES];
  logic [7:0] deg_cnt_r [NUM_BRIDGES];
  logic [7:0] off_cnt_r [NUM_BRIDGES];
  logic [1:0] tries_r [NUM_BRIDGES];
  logic [NUM_BRIDGES-1:0] s2g_r;
  logic [NUM_BRIDGES-1:0] s2vs_r;
  logic [NUM_BRIDGES-1:0] bridge_en_r;

  wire logic dis0 = global_config_reg_r[`DFP_GLOBAL_CONFIG_REG_M0_DIS];
  wire logic dis1 = global_config_reg_r[`DFP_GLOBAL_CONFIG_REG_M1_DIS];
  // Bridges of a motor are held off and reset by disable or zero off-time
  wire logic [NUM_BRIDGES-1:0] recover = {{2{dis1 | (toff1_r == 4'h0)}},
                                          {2{dis0 | (toff0_r == 4'h0)}}}; // R5 R6
  logic [NUM_BRIDGES-1:0] fault;
  logic [NUM_BRIDGES-1:0] trip;
  logic [NUM_BRIDGES-1:0] last_try;

  // Fault detection terms
  always_comb begin
    for (int b = 0; b < NUM_BRIDGES; b++) begin
      fault[b] = br_s[b].overcurrent_protection | br_s[b].hs_gnd | br_s[b].hs_sup; // R12
      trip[b] = fault[b] && (bstate_r[b] == DFP_ON) && (deg_cnt_r[b] == BLANK_CYC); // R1
      last_try[b] = (tries_r[b] == TRIES - 2'h1);
    end
  end

  // Blanking, retry and latch sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < NUM_BRIDGES; b++) begin
        bstate_r[b] <= DFP_ON;
        deg_cnt_r[b] <= 8'h00;
        off_cnt_r[b] <= 8'h00;
        tries_r[b] <= 2'h0;
      end
      s2g_r <= '0;
      s2vs_r <= '0;
    end else begin
      for (int b = 0; b < NUM_BRIDGES; b++) begin
        if (recover[b]) begin
          bstate_r[b] <= DFP_ON; // R5 R6
          deg_cnt_r[b] <= 8'h00;
          off_cnt_r[b] <= 8'h00;
          tries_r[b] <= 2'h0; // R21
          s2g_r[b] <= 1'b0;
          s2vs_r[b] <= 1'b0;
        end else begin
          case (bstate_r[b])
            DFP_ON: begin
              deg_cnt_r[b] <= (fault[b] && deg_cnt_r[b] != BLANK_CYC) ? deg_cnt_r[b] + 8'h01 :
                              (fault[b] ? deg_cnt_r[b] : 8'h00); // R1
              if (trip[b]) begin
                deg_cnt_r[b] <= 8'h00;
                off_cnt_r[b] <= 8'h00;
                tries_r[b] <= tries_r[b] + 2'h1;
                bstate_r[b] <= last_try[b] ? DFP_LATCHED : DFP_OFF; // R2 R3
                if (last_try[b]) begin
                  s2g_r[b] <= br_s[b].hs_gnd; // R3
                  s2vs_r[b] <= ~br_s[b].hs_gnd; // R3
                end
              end
            end
            DFP_OFF: begin
              off_cnt_r[b] <= off_cnt_r[b] + 8'h01;
              if (off_cnt_r[b] == RETRY_CYC - 8'h01) bstate_r[b] <= DFP_ON;
            end
            DFP_LATCHED: bstate_r[b] <= DFP_LATCHED; // R3
            default: bstate_r[b] <= DFP_ON;
          endcase
        end
      end
    end
  end

  // Bridge drive; open-load takes no part
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_en_r <= '0;
    end else begin
      for (int b = 0; b < NUM_BRIDGES; b++) begin
        bridge_en_r[b] <= (bstate_r[b] == DFP_ON) && !trip[b] && !recover[b] && !ot_r; // R2 R7 R14
      end
    end
  end

  assign bridge_enable = bridge_en_r;
  assign driver_tristate = ot_r; // R7
  assign motor0_full_scale_range = fsr0_r; // R11
  assign motor1_full_scale_range = fsr1_r; // R11
  assign temp_adc_enable = adc_en_r; // R9

  // ----------------------------------------------------------------
  // Status words and diagnostic pin
  // ----------------------------------------------------------------
  logic [31:0] stat0;
  logic [31:0] stat1;
  logic [31:0] input_status_reg;

  // Driver status per motor; open-load is live
  always_comb begin
    stat0 = 32'h0000_0000;
    stat1 = 32'h0000_0000;
    input_status_reg = 32'h0000_0000;
    stat0[`DFP_ST_SHORT_GROUND_COIL_A_FLAG] = s2g_r[0];
    stat0[`DFP_ST_SHORT_GROUND_COIL_B_FLAG] = s2g_r[1];
    stat0[`DFP_ST_SHORT_SUPPLY_COIL_A_FLAG] = s2vs_r[0];
    stat0[`DFP_ST_SHORT_SUPPLY_COIL_B_FLAG] = s2vs_r[1];
    stat0[`DFP_ST_OLA] = br_s[0].open_load; // R13
    stat0[`DFP_ST_OLB] = br_s[1].open_load; // R13
    stat0[`DFP_ST_OT] = ot_r;
    stat1[`DFP_ST_SHORT_GROUND_COIL_A_FLAG] = s2g_r[2];
    stat1[`DFP_ST_SHORT_GROUND_COIL_B_FLAG] = s2g_r[3];
    stat1[`DFP_ST_SHORT_SUPPLY_COIL_A_FLAG] = s2vs_r[2];
    stat1[`DFP_ST_SHORT_SUPPLY_COIL_B_FLAG] = s2vs_r[3];
    stat1[`DFP_ST_OLA] = br_s[2].open_load; // R13
    stat1[`DFP_ST_OLB] = br_s[3].open_load; // R13
    stat1[`DFP_ST_OT] = ot_r;
    input_status_reg[`DFP_INPUT_STATUS_REG_TEMP_MSB:`DFP_INPUT_STATUS_REG_TEMP_LSB] = temp_r; // R8
    input_status_reg[`DFP_INPUT_STATUS_REG_ADC_EN] = adc_en_r;
  end

  // Read mux for the setup phase
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_global_config_reg) rd_mux = global_config_reg_r;
    else if (hit_global_status_reg) rd_mux = 32'(uv_flag_r) << `DFP_GLOBAL_STATUS_REG_UV;
    else if (hit_input_status_reg) rd_mux = input_status_reg;
    else if (hit_drv) rd_mux = (32'(fsr1_r) << `DFP_FSR1_LSB) | (32'(fsr0_r) << `DFP_FSR0_LSB);
    else if (hit_chop0) rd_mux = 32'(toff0_r);
    else if (hit_chop1) rd_mux = 32'(toff1_r);
    else if (hit_st0) rd_mux = stat0;
    else if (hit_st1) rd_mux = stat1;
    else if (hit_pwm0) rd_mux = 32'(duty0_s); // R20
    else if (hit_pwm1) rd_mux = 32'(duty1_s); // R20
    else rd_mux = 32'h0000_0000;
  end

  // Read data captured in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= 32'h0000_0000;
    else if (rd_setup) prdata_r <= rd_mux; // R4
    else if (psel && !penable) prdata_r <= 32'h0000_0000; // R19
  end

  // Diagnostic pin, pulled low on configured conditions
  logic diag_r;
  wire logic diag_err = global_config_reg_r[`DFP_GLOBAL_CONFIG_REG_DIAGNOSTIC_OUT_ZERO_ERR] & ((|s2g_r) | (|s2vs_r) | ot_r);
  wire logic diag_uv = global_config_reg_r[`DFP_GLOBAL_CONFIG_REG_DIAGNOSTIC_OUT_ZERO_UV] & uv_flag_r; // R18
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) diag_r <= 1'b0;
    else diag_r <= diag_err | diag_uv; // R18
  end

  assign diagnostic_out_zero_o = 1'b0;
  assign diagnostic_out_zero_oe = diag_r; // R18

endmodule
`default_nettype wire

// ---- bench/dfp_stage_model.sv ----
// Power stage stand-in: turns commanded shorts into bridge current indications
`default_nettype none
module dfp_stage_model
  import dfp_pkg::*;
#(
  parameter int NB = 4
) (
  // Drive state from the block
  input wire logic [NB-1:0] bridge_enable,
  // Faults commanded by the bench
  input wire logic [NB-1:0] short_gnd,
  input wire logic [NB-1:0] short_sup,
  input wire logic [NB-1:0] spike,
  input wire logic [NB-1:0] open_load,
  // Indications back to the block
  output var dfp_pkg::dfp_bridge_in_t [NB-1:0] bridge_in
);
  // A short only carries current while its bridge drives
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      bridge_in[i].overcurrent_protection = spike[i] | (bridge_enable[i] & (short_gnd[i] | short_sup[i]));
      bridge_in[i].hs_gnd = bridge_enable[i] & short_gnd[i];
      bridge_in[i].hs_sup = bridge_enable[i] & short_sup[i];
      bridge_in[i].open_load = open_load[i];
    end
  end
endmodule
`default_nettype wire

// ---- bench/dfp_top_chk.sv ----
// Port-level assertions for the fault protection block
`default_nettype none
module dfp_top_chk
  import dfp_pkg::*;
#(
  parameter int NUM_BRIDGES = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Analog side and outputs
  input wire dfp_pkg::dfp_bridge_in_t [NUM_BRIDGES-1:0] bridge_in,
  input wire dfp_pkg::dfp_analog_in_t analog_in,
  input wire logic [NUM_BRIDGES-1:0] bridge_enable,
  input wire logic driver_tristate,
  input wire logic diagnostic_out_zero_o
);
  // ----------------------------------------
  // Run lengths of raw conditions
  // ----------------------------------------
  logic [7:0] flt_r, flt_nxt, vio_r, vio_nxt;
  wire logic fault0;
  wire logic wr_acc;

  // Fault on bridge 0, write decode, saturating next counts
  assign fault0 = bridge_in[0].overcurrent_protection | bridge_in[0].hs_gnd | bridge_in[0].hs_sup;
  assign wr_acc = psel & penable & pwrite;
  assign flt_nxt = !fault0 ? 8'h00 : (flt_r == 8'hff) ? flt_r : flt_r + 8'h01;
  assign vio_nxt = !analog_in.vio_uvlo ? 8'h00 : (vio_r == 8'hff) ? vio_r : vio_r + 8'h01;

  // Counter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_r <= 8'h00;
      vio_r <= 8'h00;
    end else begin
      flt_r <= flt_nxt;
      vio_r <= vio_nxt;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ready_zero_wait: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_pin_low_only: assert property (diagnostic_out_zero_o == 1'b0)
    else $error("diagnostic pin driven high");
  a_trip_after_blank: assert property ($fell(bridge_enable[0]) && !driver_tristate && !$past(wr_acc)
    && !$past(wr_acc, 2) && !$past(wr_acc, 3) |-> flt_r >= 8'd26)
    else $error("bridge off before blanking");
  a_trip_deadline: assert property (flt_r >= 8'd30 |-> !bridge_enable[0])
    else $error("bridge kept on under fault");
  a_retry_pause: assert property ($fell(bridge_enable[0]) && flt_r >= 8'd26 |-> !bridge_enable[0] [*8])
    else $error("retry too soon");
  a_ot_all_off: assert property (driver_tristate && $past(driver_tristate) |-> bridge_enable == '0)
    else $error("bridge on while tristated");
  a_ot_cause: assert property ($rose(driver_tristate) |-> $past(analog_in.temp_hot, 2)
    || $past(analog_in.temp_hot, 3) || $past(analog_in.temp_hot, 4))
    else $error("tristate without hot die");
  a_ot_release: assert property ($fell(driver_tristate) |-> $past(analog_in.temp_cool, 2)
    || $past(analog_in.temp_cool, 3) || $past(analog_in.temp_cool, 4))
    else $error("tristate left without cool die");
  a_vio_silent: assert property (psel && penable && vio_r >= 8'd6 |-> prdata == 32'h0 && !pslverr)
    else $error("answer during io undervoltage");

  // Main scenarios reached
  c_trip: cover property ($fell(bridge_enable[0]) && flt_r >= 8'd26);
  c_ot: cover property ($rose(driver_tristate));
  c_err: cover property (pslverr);
endmodule

bind dfp_top dfp_top_chk #(.NUM_BRIDGES(NUM_BRIDGES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bridge_in(bridge_in), .analog_in(analog_in), .bridge_enable(bridge_enable),
  .driver_tristate(driver_tristate), .diagnostic_out_zero_o(diagnostic_out_zero_o));
`default_nettype wire

// ---- bench/test_driver_fault_protection.sv ----
// Self-checking bench for the fault protection block
`default_nettype none
module test_driver_fault_protection;
  timeunit 1ns;
  timeprecision 1ps;
  import dfp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tris, aen, dgo, dgoe, ev;
  logic [31:0] paddr, pwdata, prdata, rv;
  dfp_bridge_in_t [3:0] bin;
  dfp_analog_in_t ana;
  logic [7:0] tcode;
  logic [8:0] duty0, duty1;
  logic [3:0] be, sg, ss, spk, ol;
  logic [1:0] fsr0, fsr1;
  logic [31:0] mdl [64];
  int num_errors, total_checks;

  dfp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bridge_in(bin), .analog_in(ana), .temp_adc_code(tcode), .motor0_pwm_duty(duty0),
    .motor1_pwm_duty(duty1), .bridge_enable(be), .driver_tristate(tris), .motor0_full_scale_range(fsr0),
    .motor1_full_scale_range(fsr1), .temp_adc_enable(aen), .diagnostic_out_zero_o(dgo),
    .diagnostic_out_zero_oe(dgoe));
  dfp_stage_model u_stage (.bridge_enable(be), .short_gnd(sg), .short_sup(ss), .spike(spk),
    .open_load(ol), .bridge_in(bin));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d, rv, ev);
    mdl[i] = d;
    chk("write response", 32'h0, 32'(ev));
  endtask

  task automatic rd(input logic [5:0] i, input logic [31:0] m, input string what);
    apb(1'b0, {i, 2'b00}, 32'h0, rv, ev);
    chk(what, mdl[i] & m, rv & m);
  endtask

  task automatic wait_be(input int b, input logic v);
    int n;
    n = 0;
    while (be[b] !== v && n < 300) begin
      @(negedge pclk);
      n++;
    end
    chk("bridge wait", 32'h1, 32'(n < 300));
  endtask

  // Three trips, then the bridge stays off
  task automatic latch_bridge(input int b);
    for (int t = 0; t < 3; t++) begin
      wait_be(b, 1'b0);
      if (t < 2) wait_be(b, 1'b1);
    end
    repeat (200) @(negedge pclk);
    chk("latched bridge", 32'h0, 32'(be[b]));
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    give_verdict;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, pwdata, tcode, duty0, duty1, ana} = '0;
    {sg, ss, spk, ol} = 16'h0;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(27522));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    mdl[5] = 32'hf;
    mdl[16] = 32'h3;
    mdl[4] = 32'h200;
    rd(5, 32'hf, "range reset");
    rd(16, 32'hf, "off time reset");
    rd(4, 32'h200, "adc enable reset");
    chk("adc pin", 32'h1, 32'(aen));
    for (int c = 0; c < 16; c++) begin
      wr(5, 32'(c));
      repeat (2) @(negedge pclk);
      chk("range pins", 32'(c), {28'h0, fsr1, fsr0});
    end
    @(posedge pclk) spk[0] <= 1'b1;
    repeat (15) @(posedge pclk);
    spk[0] <= 1'b0;
    repeat (40) @(negedge pclk);
    chk("glitch", 32'hf, 32'(be));
    @(posedge pclk) sg[0] <= 1'b1;
    latch_bridge(0);
    chk("other bridges", 32'he, 32'(be));
    mdl[18] = 32'h1;
    rd(18, 32'h7f, "short flags m0");
    wr(17, 32'h5);
    rd(17, 32'hf, "config while latched");
    @(posedge pclk) sg[0] <= 1'b0;
    wr(0, 32'h4000);
    wr(0, 32'h0);
    wait_be(0, 1'b1);
    mdl[18] = 32'h0;
    rd(18, 32'h7f, "flags after disable");
    @(posedge pclk) sg[0] <= 1'b1;
    wait_be(0, 1'b0);
    wait_be(0, 1'b1);
    @(posedge pclk) sg[0] <= 1'b0;
    @(posedge pclk) ss[2] <= 1'b1;
    latch_bridge(2);
    mdl[19] = 32'h4;
    rd(19, 32'h7f, "short flags m1");
    @(posedge pclk) ss[2] <= 1'b0;
    wr(17, 32'h0);
    repeat (2) @(negedge pclk);
    chk("off time zero", 32'h3, 32'(be));
    wr(17, 32'h9);
    wait_be(2, 1'b1);
    mdl[19] = 32'h0;
    rd(19, 32'h7f, "flags after off time");
    @(posedge pclk) ana.temp_hot <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("tristate", 32'h1, 32'(tris));
    mdl[18] = 32'h40;
    rd(18, 32'h40, "ot flag");
    @(posedge pclk) ana.temp_hot <= 1'b0;
    ana.temp_cool <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("restart", 32'hf, {27'h0, tris, be});
    @(posedge pclk) tcode <= 8'($urandom);
    duty0 <= 9'($urandom);
    duty1 <= 9'($urandom);
    ol <= 4'h1;
    ana.adc_valid <= 1'b1;
    repeat (8) @(posedge pclk);
    mdl[4] = {22'h0, 1'b1, tcode, 1'b0};
    mdl[20] = {23'h0, duty0};
    mdl[21] = {23'h0, duty1};
    mdl[18] = 32'h10;
    rd(4, 32'h3fe, "temperature");
    rd(20, 32'h1ff, "duty m0");
    rd(21, 32'h1ff, "duty m1");
    rd(18, 32'h7f, "open load flag");
    chk("open load drive", 32'hf, 32'(be));
    wr(4, 32'h0);
    mdl[4][8:1] = tcode;
    @(posedge pclk) tcode <= ~tcode;
    repeat (8) @(negedge pclk);
    chk("adc pin off", 32'h0, 32'(aen));
    rd(4, 32'h3fe, "held temperature");
    @(posedge pclk) ana.vs_uvlo <= 1'b1;
    repeat (4) @(posedge pclk);
    ana.vs_uvlo <= 1'b0;
    mdl[1] = 32'h10;
    rd(1, 32'h10, "uv flag");
    wr(0, 32'h10);
    repeat (3) @(negedge pclk);
    chk("diag pin", 32'h1, 32'(dgoe));
    wr(1, 32'h0);
    mdl[1] = 32'h10;
    rd(1, 32'h10, "uv kept");
    wr(1, 32'h10);
    mdl[1] = 32'h0;
    rd(1, 32'h10, "uv cleared");
    repeat (3) @(negedge pclk);
    chk("diag pin off", 32'h0, 32'(dgoe));
    apb(1'b0, 8'hfc, 32'h0, rv, ev);
    chk("unmapped data", 32'h0, rv);
    chk("unmapped error", 32'h1, 32'(ev));
    @(posedge pclk) ana.vio_uvlo <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, 8'h14, 32'h0, rv, ev);
    apb(1'b0, 8'h14, 32'h0, rv, ev);
    chk("silent read", 32'h0, rv);
    chk("silent error", 32'h0, 32'(ev));
    @(posedge pclk) ana.vio_uvlo <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(5, 32'hf, "range kept");
    give_verdict;
  end
endmodule
`default_nettype wire
